// >>> inc/rstc_params.svh
`ifndef RSTC_PARAMS_SVH
`define RSTC_PARAMS_SVH
// Port latch reset value, all ones
`define RSTC_PORT_LATCH_RST   8'hFF
// Start address after any reset
`define RSTC_RESET_VECTOR     16'h0000
// External memory byte that may be clobbered
`define RSTC_XRAM_CLOBBER_ADR 16'h0000
`define RSTC_XRAM_CLOBBER_VAL 8'h00
// Stack pointer reset value
`define RSTC_SP_RST           8'h07
// Watchdog prescale ratio
`define RSTC_WDT_DIV          4'hC
// Clock select code of the internal oscillator
`define RSTC_CLKSEL_INT       2'h0
// Reset cause register bit of the power-on flag
`define RSTC_POR_FLAG_BIT     1
`endif

// >>> inc/rstc_pkg.sv
package rstc_pkg;
  // Controller states, one-hot
  typedef enum logic [2:0] {
    RSTC_RUN   = 3'h1,
    RSTC_HOLD  = 3'h2,
    RSTC_CLEAN = 3'h4
  } rstc_state_e;
  // Kind of reset being served
  typedef enum logic [1:0] {
    RSTC_KIND_NONE = 2'h0,
    RSTC_KIND_POR  = 2'h1,
    RSTC_KIND_VMON = 2'h2,
    RSTC_KIND_OTHR = 2'h3
  } rstc_kind_e;
endpackage

// >>> tb/rstc_src_model.sv
// Reset sources and the board around the reset pin
module rstc_src_model (
  input  wire logic rstPinOut,    // Device drive value on reset pin
  input  wire logic rstPinOeN,    // Device drive enable, low drives
  input  wire logic rstPinPullEn, // Device weak pull-up, board resistor dominates
  output logic      porReq,       // Power-on detector level
  output logic      vmonReq,      // Supply monitor trip level
  output logic      pinReqN,      // Resolved reset pin fed back to device
  output logic      otherReq,     // Software or watchdog level
  output logic      pinLevel      // Resolved reset pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic buttonDown; // External push button pulls pin low

  initial begin
    porReq     = 1'b0;
    vmonReq    = 1'b0;
    otherReq   = 1'b0;
    buttonDown = 1'b0;
  end

  // Device drive wins, then button, else board pull-up keeps it high
  assign pinLevel = !rstPinOeN ? rstPinOut : (buttonDown ? 1'b0 : 1'b1);
  assign pinReqN  = pinLevel;

  // Bench calls this just after a falling edge
  task automatic set_src(input int idx, input logic val);
    case (idx)
      0: porReq = val;
      1: vmonReq = val;
      2: buttonDown = val;
      default: otherReq = val;
    endcase
  endtask
endmodule

// >>> tb/test_reset_state_controller.sv
module test_reset_state_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, monDisSet, porReq, vmonReq, pinReqN, otherReq, pinLevel;
  logic coreHalt, sfrInit, irqDisable, timerDisable, ramWriteBlock, stackPtrLoad, portForce;
  logic portOpenDrain, weakPullupEn, rstPinOut, rstPinOeN, rstPinPullEn, pcLoad, wdtEnable;
  logic xramZeroWr, powerOnResetFlag, supplyMonitorDisable;
  logic [7:0] stackPtrInit, portLatch, xramZeroDat;
  logic [15:0] pcInit, xramZeroAdr;
  logic [1:0] clkSel;
  logic [3:0] wdtDiv;
  int nErrors = 0;
  int numChecks = 0;

  rstc_reset_state_controller #(.PW(8)) uut (.clk(clk), .rst(rst), .porReq(porReq), .vmonReq(vmonReq),
    .pinReqN(pinReqN), .otherReq(otherReq), .monDisSet(monDisSet), .coreHalt(coreHalt), .sfrInit(sfrInit),
    .irqDisable(irqDisable), .timerDisable(timerDisable), .ramWriteBlock(ramWriteBlock),
    .stackPtrInit(stackPtrInit), .stackPtrLoad(stackPtrLoad), .portLatch(portLatch), .portForce(portForce),
    .portOpenDrain(portOpenDrain), .weakPullupEn(weakPullupEn), .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN),
    .rstPinPullEn(rstPinPullEn), .pcInit(pcInit), .pcLoad(pcLoad), .clkSel(clkSel), .wdtEnable(wdtEnable),
    .wdtDiv(wdtDiv), .xramZeroWr(xramZeroWr), .xramZeroAdr(xramZeroAdr), .xramZeroDat(xramZeroDat),
    .powerOnResetFlag(powerOnResetFlag), .supplyMonitorDisable(supplyMonitorDisable));
  rstc_src_model uSrc (.rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN), .rstPinPullEn(rstPinPullEn),
    .porReq(porReq), .vmonReq(vmonReq), .pinReqN(pinReqN), .otherReq(otherReq), .pinLevel(pinLevel));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared checking and waiting
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait for the halt level; a stuck controller ends the run
  task automatic wait_halt(input logic lvl);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (coreHalt === lvl) return;
    end
    nErrors++;
    $display("CHECK FAILED coreHalt wait expected %h seen %h", lvl, coreHalt);
    final_report();
  endtask

  // Core, port and stack controls that must hold while the core is stopped
  task automatic check_held();
    check("coreHalt", coreHalt, 1'b1);
    check("sfrInit", sfrInit, 1'b1);
    check("portForce", portForce, 1'b1);
    check("irqDisable", irqDisable, 1'b1);
    check("timerDisable", timerDisable, 1'b1);
    check("ramWriteBlock", ramWriteBlock, 1'b1);
    check("stackPtrLoad", stackPtrLoad, 1'b1);
    check("stackPtrInit", stackPtrInit, 8'h07);
    check("portLatch", portLatch, 8'hFF);
    check("portOpenDrain", portOpenDrain, 1'b1);
    check("weakPullupEn", weakPullupEn, 1'b1);
  endtask

  // Sampled in the cycle where the halt has just fallen
  task automatic check_exit(input logic expFlag);
    check("pcLoad", pcLoad, 1'b1);
    check("pcInit", pcInit, 16'h0000);
    check("clkSel", clkSel, 2'h0);
    check("wdtEnable", wdtEnable, 1'b1);
    check("wdtDiv", wdtDiv, 4'hC);
    check("xramZeroWr", xramZeroWr, 1'b1);
    check("xramZeroAdr", xramZeroAdr, 16'h0000);
    check("xramZeroDat", xramZeroDat, 8'h00);
    check("weakPullupEn", weakPullupEn, 1'b1);
    check("powerOnResetFlag", powerOnResetFlag, expFlag);
    @(negedge clk);
    check("pcLoad", pcLoad, 1'b0);
    // Let any pin echo of a driven reset die out before the next scenario
    repeat (12) @(negedge clk);
    wait_halt(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_power_on();
    @(negedge clk);
    check_held();
    check("rstPinOeN", rstPinOeN, 1'b1);
    check("rstPinPullEn", rstPinPullEn, 1'b0);
    wait_halt(1'b0);
    check_exit(1'b1);
  endtask

  // Power-on, monitor and other sources; pin behaviour differs by kind
  task automatic sc_source(input int idx);
    uSrc.set_src(idx, 1'b1);
    wait_halt(1'b1);
    monDisSet = 1'b1;
    repeat (2) @(negedge clk);
    monDisSet = 1'b0;
    check_held();
    check("rstPinOeN", rstPinOeN, idx == 1 ? 1'b0 : 1'b1);
    check("rstPinOut", rstPinOut, 1'b0);
    check("pinLevel", pinLevel, idx == 1 ? 1'b0 : 1'b1);
    check("rstPinPullEn", rstPinPullEn, idx == 3 ? 1'b1 : 1'b0);
    uSrc.set_src(idx, 1'b0);
    wait_halt(1'b0);
    check("supplyMonitorDisable", supplyMonitorDisable, 1'b0);
    check_exit(idx == 3 ? 1'b0 : 1'b1);
  endtask

  // Overlapping pin and other sources: release waits for the last one
  task automatic sc_overlap();
    uSrc.set_src(2, 1'b1);
    uSrc.set_src(3, 1'b1);
    wait_halt(1'b1);
    uSrc.set_src(3, 1'b0);
    repeat (8) @(negedge clk);
    check("coreHalt", coreHalt, 1'b1);
    uSrc.set_src(2, 1'b0);
    wait_halt(1'b0);
    check_exit(1'b0);
  endtask

  // Monitor disabled: a software-class reset becomes a full power-on
  task automatic sc_escalate();
    monDisSet = 1'b1;
    @(negedge clk);
    monDisSet = 1'b0;
    repeat (2) @(negedge clk);
    check("supplyMonitorDisable", supplyMonitorDisable, 1'b1);
    uSrc.set_src(3, 1'b1);
    wait_halt(1'b1);
    uSrc.set_src(3, 1'b0);
    wait_halt(1'b0);
    check("supplyMonitorDisable", supplyMonitorDisable, 1'b0);
    check_exit(1'b1);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    monDisSet = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    sc_power_on();
    sc_source(0);
    sc_source(1);
    sc_source(3);
    sc_overlap();
    sc_escalate();
    final_report();
  end
endmodule

// >>> verilog/rstc_reset_state_controller.sv
`include "rstc_params.svh"

module rstc_reset_state_controller #(
  parameter int PW = 8 // Port width
) (
  input  wire logic          clk,           // System clock
  input  wire logic          rst,           // Synchronous reset
  input  wire logic          porReq,        // Power-on detector level, async
  input  wire logic          vmonReq,       // Supply monitor trip level, async
  input  wire logic          pinReqN,       // Reset pin input, active low, async
  input  wire logic          otherReq,      // Other sources (software, watchdog)
  input  wire logic          monDisSet,     // Firmware pulse: disable supply monitor
  output logic               coreHalt,      // Core stopped
  output logic               sfrInit,       // Load register reset values
  output logic               irqDisable,    // Interrupts masked
  output logic               timerDisable,  // Timers stopped
  output logic               ramWriteBlock, // Data RAM writes blocked
  output logic [7:0]         stackPtrInit,  // Stack pointer reload value
  output logic               stackPtrLoad,  // Stack pointer load strobe
  output logic [PW-1:0]      portLatch,     // Port latch force value
  output logic               portForce,     // Port forced to reset state
  output logic               portOpenDrain, // Port open-drain mode
  output logic               weakPullupEn,  // Port weak pull-ups
  output logic               rstPinOut,     // Reset pin drive value
  output logic               rstPinOeN,     // Reset pin enable, low drives
  output logic               rstPinPullEn,  // Reset pin weak pull-up
  output logic [15:0]        pcInit,        // Program counter on exit
  output logic               pcLoad,        // PC load pulse at release
  output logic [1:0]         clkSel,        // System clock source
  output logic               wdtEnable,     // Watchdog enable
  output logic [3:0]         wdtDiv,        // Watchdog prescale
  output logic               xramZeroWr,    // Optional write of external byte zero
  output logic [15:0]        xramZeroAdr,   // Its address
  output logic [7:0]         xramZeroDat,   // Its data
  output logic               powerOnResetFlag,   // Power-on cause flag
  output logic               supplyMonitorDisable // Monitor disabled state
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    rstc_pkg::rstc_state_e fsm;     // Controller state
    rstc_pkg::rstc_kind_e  kind;    // Reset kind served
    logic                  flag;    // Power-on flag
    logic                  supply_monitor_disable;  // Monitor disabled
    logic                  halt;    // Core halt
    logic                  pinOeN;  // Reset pin enable, low drives
    logic                  pinPull; // Reset pin pull-up
    logic                  pcLd;    // PC load pulse
    logic                  zeroWr;  // External byte zero write pulse
    logic                  wdtOn;   // Watchdog running
    logic                  fresh;   // First cycle after rst
    logic [1:0]            drvHist; // Own pin drive, last two cycles
  } rstc_ctrl_s;

  rstc_ctrl_s state_reg;  // Registered state
  rstc_ctrl_s state_next; // Next state

  logic [3:0] syncIn;  // Raw source levels
  logic [3:0] syncOut; // Synchronised levels
  logic       porS;    // Power-on level
  logic       vmonS;   // Monitor level
  logic       pinS;    // Pin level, active high
  logic       anyReq;  // Any source
  logic       pinEcho; // Pin low is our own drive

  // Pin is active low; invert before syncing so all levels read active high
  assign syncIn = {otherReq, ~pinReqN, vmonReq, porReq};

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop crossing of the asynchronous levels
  rstc_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (syncIn),
    .dout (syncOut)
  );

  assign porS    = syncOut[0];
  assign vmonS   = syncOut[1];
  // Our own low drive echoes back through the pin and both sync flops;
  // the pin is ignored until that echo drains, or a monitor reset never ends.
  // Limitation: a button press inside that window is not seen by itself.
  assign pinEcho = !state_reg.pinOeN || (|state_reg.drvHist);
  assign pinS    = syncOut[2] && !pinEcho;
  assign anyReq  = porS || vmonS || pinS || syncOut[3];

  // Classify a request; power-on wins over monitor over others
  function automatic rstc_pkg::rstc_kind_e classify(input logic p, input logic v, input logic md);
    if (p || md) begin
      return rstc_pkg::RSTC_KIND_POR;
    end else if (v) begin
      return rstc_pkg::RSTC_KIND_VMON;
    end else begin
      return rstc_pkg::RSTC_KIND_OTHR;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next        = state_reg;
    state_next.pcLd   = 1'b0;
    state_next.zeroWr = 1'b0;
    state_next.fresh  = 1'b0;
    // Delay line of our own drive, as deep as the synchroniser
    state_next.drvHist = {state_reg.drvHist[0], !state_reg.pinOeN};
    // Firmware may turn the monitor off while running
    if (monDisSet && state_reg.fsm == rstc_pkg::RSTC_RUN) begin
      state_next.supply_monitor_disable = 1'b1;
    end
    case (state_reg.fsm)
      rstc_pkg::RSTC_RUN: begin
        if (anyReq || state_reg.fresh) begin
          // Entry: halt core, stop watchdog until exit
          state_next.fsm   = rstc_pkg::RSTC_HOLD;
          state_next.halt  = 1'b1;
          state_next.wdtOn = 1'b0;
          state_next.kind  = state_reg.fresh ? rstc_pkg::RSTC_KIND_POR
                             : classify(porS, vmonS, state_reg.supply_monitor_disable);
        end
      end
      rstc_pkg::RSTC_HOLD: begin
        // Upgrade kind if a stronger source appears mid-reset
        if (porS || state_reg.supply_monitor_disable) begin
          state_next.kind = rstc_pkg::RSTC_KIND_POR;
        end else if (vmonS && state_reg.kind == rstc_pkg::RSTC_KIND_OTHR) begin
          state_next.kind = rstc_pkg::RSTC_KIND_VMON;
        end
        if (!anyReq) begin
          state_next.fsm = rstc_pkg::RSTC_CLEAN;
        end
      end
      rstc_pkg::RSTC_CLEAN: begin
        if (anyReq) begin
          // A source came back on the way out; treat it as one longer reset
          state_next.fsm = rstc_pkg::RSTC_HOLD;
        end else begin
          // Exit: flag, monitor, PC, watchdog; byte zero may be cleared
          state_next.fsm     = rstc_pkg::RSTC_RUN;
          state_next.halt    = 1'b0;
          state_next.pinOeN  = 1'b1;
          state_next.pinPull = 1'b1;
          state_next.pcLd    = 1'b1;
          state_next.wdtOn   = 1'b1;
          state_next.zeroWr  = 1'b1;
          state_next.flag    = (state_reg.kind != rstc_pkg::RSTC_KIND_OTHR);
          if (state_reg.kind == rstc_pkg::RSTC_KIND_POR) begin
            state_next.supply_monitor_disable = 1'b0;
          end
          state_next.kind    = rstc_pkg::RSTC_KIND_NONE;
        end
      end
      default: begin
        state_next.fsm  = rstc_pkg::RSTC_HOLD;
        state_next.halt = 1'b1;
      end
    endcase
    // Reset pin follows the kind from the first held cycle, not one late:
    // undriven and no pull for power-on, low for monitor
    if (state_next.fsm == rstc_pkg::RSTC_HOLD) begin
      state_next.pinOeN  = (state_next.kind != rstc_pkg::RSTC_KIND_VMON);
      state_next.pinPull = (state_next.kind == rstc_pkg::RSTC_KIND_OTHR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; rst counts as a power-on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.fsm     <= rstc_pkg::RSTC_RUN;
      state_reg.kind    <= rstc_pkg::RSTC_KIND_POR;
      state_reg.flag    <= 1'b0;
      state_reg.supply_monitor_disable  <= 1'b0;
      state_reg.halt    <= 1'b1;
      state_reg.pinOeN  <= 1'b1;
      state_reg.pinPull <= 1'b0;
      state_reg.pcLd    <= 1'b0;
      state_reg.zeroWr  <= 1'b0;
      state_reg.wdtOn   <= 1'b0;
      state_reg.fresh   <= 1'b1;
      state_reg.drvHist <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flops or constants
  assign coreHalt      = state_reg.halt;
  assign sfrInit       = state_reg.halt;
  assign irqDisable    = state_reg.halt;
  assign timerDisable  = state_reg.halt;
  // RAM holds data; only the stray strobe path is fenced while halted
  assign ramWriteBlock = state_reg.halt;
  assign stackPtrInit  = `RSTC_SP_RST;
  assign stackPtrLoad  = state_reg.halt;
  assign portLatch     = {PW{1'b1}};
  assign portForce     = state_reg.halt;
  assign portOpenDrain = state_reg.halt;
  // Pull-ups stay on in and out of reset; firmware owns them later
  assign weakPullupEn  = 1'b1;
  assign rstPinOut     = 1'b0;
  assign rstPinOeN     = state_reg.pinOeN;
  assign rstPinPullEn  = state_reg.pinPull;
  assign pcInit        = `RSTC_RESET_VECTOR;
  assign pcLoad        = state_reg.pcLd;
  assign clkSel        = `RSTC_CLKSEL_INT;
  assign wdtEnable     = state_reg.wdtOn;
  assign wdtDiv        = `RSTC_WDT_DIV;
  assign xramZeroWr    = state_reg.zeroWr;
  assign xramZeroAdr   = `RSTC_XRAM_CLOBBER_ADR;
  assign xramZeroDat   = `RSTC_XRAM_CLOBBER_VAL;
  assign powerOnResetFlag     = state_reg.flag;
  assign supplyMonitorDisable = state_reg.supply_monitor_disable;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // A synced request always leaves the core stopped next cycle
  AST_HALT_WHILE_REQ: assert property (@(posedge clk) disable iff (rst)
    anyReq |=> coreHalt)
    else $error("core runs during reset");

  // No release while a source is still asserted
  AST_HOLD_TILL_FREE: assert property (@(posedge clk) disable iff (rst)
    (state_reg.fsm == rstc_pkg::RSTC_HOLD && anyReq) |=> state_reg.fsm == rstc_pkg::RSTC_HOLD)
    else $error("released while a source holds");

  // Two quiet cycles out of hold bring the core back
  AST_RELEASE_BOUND: assert property (@(posedge clk) disable iff (rst)
    (state_reg.fsm == rstc_pkg::RSTC_HOLD && !anyReq) ##1 !anyReq |-> ##1 !coreHalt)
    else $error("release late");

  // A source seen in the exit cycle sends the controller back to hold
  AST_CLEAN_REENTER: assert property (@(posedge clk) disable iff (rst)
    (state_reg.fsm == rstc_pkg::RSTC_CLEAN && anyReq) |=> coreHalt && state_reg.fsm == rstc_pkg::RSTC_HOLD)
    else $error("released past a new source");

  // Monitor reset keeps the pin pulled low
  AST_VMON_PIN_LOW: assert property (@(posedge clk) disable iff (rst)
    (state_reg.fsm == rstc_pkg::RSTC_HOLD && state_reg.kind == rstc_pkg::RSTC_KIND_VMON
     && $past(state_reg.fsm) == rstc_pkg::RSTC_HOLD && !state_reg.supply_monitor_disable && !porS)
    |=> !rstPinOeN)
    else $error("pin not driven");

  // Power-on reset leaves the pin floating with no pull
  AST_POR_PIN_FREE: assert property (@(posedge clk) disable iff (rst)
    (state_reg.kind == rstc_pkg::RSTC_KIND_POR) |=> (rstPinOeN && !rstPinPullEn) || !coreHalt)
    else $error("pin busy in power-on");

  // Power-on exit sets the flag and turns the monitor back on
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
    (state_reg.fsm == rstc_pkg::RSTC_CLEAN && state_reg.kind == rstc_pkg::RSTC_KIND_POR && !anyReq)
    |=> powerOnResetFlag && !supplyMonitorDisable)
    else $error("power-on exit wrong");

  // A reset served as other-class (pin, software, watchdog) clears the flag on exit
  AST_FLAG_CLR: assert property (@(posedge clk) disable iff (rst)
    (state_reg.fsm == rstc_pkg::RSTC_CLEAN && state_reg.kind == rstc_pkg::RSTC_KIND_OTHR && !anyReq)
    |=> !powerOnResetFlag)
    else $error("flag not cleared");

  // Release comes with PC load, watchdog on and the byte-zero write
  AST_EXIT_PULSE: assert property (@(posedge clk) disable iff (rst)
    $fell(coreHalt) |-> pcLoad && wdtEnable && xramZeroWr)
    else $error("exit actions missing");

  // With the monitor off every source is served as power-on
  AST_SUPPLY_MONITOR_DISABLE_ESC: assert property (@(posedge clk) disable iff (rst)
    (supplyMonitorDisable && state_reg.fsm == rstc_pkg::RSTC_RUN && anyReq)
    |=> state_reg.kind == rstc_pkg::RSTC_KIND_POR)
    else $error("no escalation");

  // Firmware cannot turn the monitor off while the core is held
  AST_SUPPLY_MONITOR_DISABLE_REFUSED: assert property (@(posedge clk) disable iff (rst)
    (monDisSet && state_reg.fsm == rstc_pkg::RSTC_HOLD && !supplyMonitorDisable)
    |=> !supplyMonitorDisable)
    else $error("monitor disabled during reset");

  // Watchdog stays off through the shortest possible reset
  AST_WDT_OFF_HALT: assert property (@(posedge clk) disable iff (rst)
    $rose(coreHalt) |-> !wdtEnable [*2])
    else $error("watchdog on in reset");

  COV_POR:  cover property (@(posedge clk) disable iff (rst)
    state_reg.fsm == rstc_pkg::RSTC_CLEAN && state_reg.kind == rstc_pkg::RSTC_KIND_POR);
  COV_VMON: cover property (@(posedge clk) disable iff (rst)
    state_reg.fsm == rstc_pkg::RSTC_CLEAN && state_reg.kind == rstc_pkg::RSTC_KIND_VMON);
  COV_OTHR: cover property (@(posedge clk) disable iff (rst)
    state_reg.fsm == rstc_pkg::RSTC_CLEAN && state_reg.kind == rstc_pkg::RSTC_KIND_OTHR);
  COV_ESC:  cover property (@(posedge clk) disable iff (rst) supplyMonitorDisable && anyReq);
  COV_REENTER: cover property (@(posedge clk) disable iff (rst)
    state_reg.fsm == rstc_pkg::RSTC_CLEAN && anyReq);
endmodule

// >>> verilog/rstc_sync.sv
// Two-flop synchroniser for asynchronous reset-source levels
module rstc_sync #(
  parameter int W = 4 // Number of levels
) (
  input  wire logic         clk,  // System clock
  input  wire logic         rst,  // Synchronous reset
  input  wire logic [W-1:0] din,  // Raw levels
  output logic      [W-1:0] dout  // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] stage1; // First flop, read only by second
    logic [W-1:0] stage2; // Second flop
  } rstc_sync_s;
  rstc_sync_s state_reg;
  rstc_sync_s state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: plain shift
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = din;
    state_next.stage2 = state_reg.stage1;
  end

  // Register; reset clears both stages
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.stage2;
endmodule
